// [common/core_pkg.sv]
// Shared constants, encodings and types of the core execution slice
package core_pkg;
    localparam int PC_W     = 21;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 8;
    localparam int INSTR_W  = 16;
    localparam int BANK_W   = 4;
    localparam int FLAG_W   = 5;
    localparam int RADDR_W  = 8;
    // Opcode fields
    localparam int OPC_MSB  = 15;
    localparam int OPC_LSB  = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam logic [5:0]  OPC_MINUS     = 6'h01;
    localparam logic [5:0]  OPC_PLUS      = 6'h0A;
    localparam logic [5:0]  OPC_MINUS_SZ  = 6'h0B;
    localparam logic [5:0]  OPC_MINUS_SNZ = 6'h13;
    localparam logic [15:0] OP_BCD        = 16'h0007;
    localparam logic [7:0]  OP_JUMP1      = 8'hEF;
    localparam logic [3:0]  OP_WORD2      = 4'hF;
    localparam logic [3:0]  OP_MOVE2      = 4'hC;
    localparam logic [6:0]  OP_CALL2      = 7'h76;
    localparam logic [7:0]  OP_LOADPTR2   = 8'hEE;
    // Status flag positions
    localparam int FL_C  = 0;
    localparam int FL_DC = 1;
    localparam int FL_Z  = 2;
    localparam int FL_OV = 3;
    localparam int FL_N  = 4;
    // Arithmetic constants
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [8:0] BCD_LO6   = 9'h006;
    localparam logic [7:0] BCD_HI6   = 8'h60;
    localparam logic [7:0] BYTE_MAX  = 8'hFF;
    localparam logic [3:0] NIB_MAX   = 4'hF;
    localparam logic [7:0] SIGN_MIN  = 8'h80;
    localparam logic [7:0] SIGN_MAX  = 8'h7F;
    localparam logic [7:0] ONE8      = 8'h01;
    localparam logic [20:0] PC_STEP  = 21'h000002;
    // Access bank split
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;
    // Register map
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_INDEX = 8'h04;
    localparam logic [7:0] OFS_ACC   = 8'h08;
    localparam logic [7:0] OFS_PC    = 8'h0C;
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_EXT   = 1;
    localparam int CTRL_BANK  = 4;
    localparam int ACC_FLAGS  = 8;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam int HTRANS_ACT = 1;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    typedef enum logic [2:0] {
        CYC_EXEC = 3'b001,
        CYC_SKIP = 3'b010,
        CYC_JNOP = 3'b100
    } cycle_t;

    // Words that open a two-word instruction
    function automatic logic two_word(input logic [15:0] w);
        two_word = (w[15:12] == OP_MOVE2) || (w[15:9] == OP_CALL2) ||
                   (w[15:8] == OP_LOADPTR2) || (w[15:8] == OP_JUMP1);
    endfunction
endpackage

// [common/regs_if.sv]
// Control and status carrier between register slave and core
`timescale 1ns/1ps
interface regs_if;
    logic        run_en;
    logic        ext_en;
    logic [3:0]  bank_pointer;
    logic [11:0] index_base;
    logic [7:0]  acc;
    logic [4:0]  flags;
    logic [20:0] pc;
    modport regs (output run_en, ext_en, bank_pointer, index_base, input acc, flags, pc);
    modport core (input run_en, ext_en, bank_pointer, index_base, output acc, flags, pc);
endinterface

// [verilog/reg_slave.sv]
// AHB-Lite register slave for control and status words
`timescale 1ns/1ps
module reg_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    regs_if.regs             rif
);
    logic [31:0] ctrl_reg;
    logic [11:0] index_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  waddr_reg;
    logic        wpend_reg;
    logic [31:0] rd_mux;
    wire         take = hsel_i && htrans_i[core_pkg::HTRANS_ACT] && hready_i;
    wire [7:0]   a8   = haddr_i[7:0];

    // Read mux; unmapped offsets read zero
    assign rd_mux = (a8 == core_pkg::OFS_CTRL)  ? ctrl_reg :
                    (a8 == core_pkg::OFS_INDEX) ? {20'h00000, index_reg} :
                    (a8 == core_pkg::OFS_ACC)   ? {19'h00000, rif.flags, rif.acc} :
                    (a8 == core_pkg::OFS_PC)    ? {11'h000, rif.pc} : 32'h00000000;

    // Address phase capture; read data registered for the data phase
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wpend_reg <= 1'b0;
            waddr_reg <= 8'h00;
            rdata_reg <= 32'h00000000;
        end
        else if (hready_i)
        begin
            wpend_reg <= take && hwrite_i;
            waddr_reg <= a8;
            rdata_reg <= (take && !hwrite_i) ? rd_mux : 32'h00000000;
        end
    end

    // Data phase writes; status words ignore writes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg  <= core_pkg::CTRL_RESET;
            index_reg <= 12'h000;
        end
        else if (wpend_reg)
        begin
            if (waddr_reg == core_pkg::OFS_CTRL)
                ctrl_reg <= hwdata_i & 32'h000000F3;
            if (waddr_reg == core_pkg::OFS_INDEX)
                index_reg <= hwdata_i[11:0];
        end
    end

    assign hrdata_o         = rdata_reg;
    assign rif.run_en       = ctrl_reg[core_pkg::CTRL_RUN];
    assign rif.ext_en       = ctrl_reg[core_pkg::CTRL_EXT];
    assign rif.bank_pointer = ctrl_reg[core_pkg::CTRL_BANK +: 4];
    assign rif.index_base   = index_reg;
endmodule

// [verilog/cpu_incdec_bcd_jump_ops.sv]
// Execution slice: BCD adjust, inc/dec, dec-and-skip, absolute jump
// Contract
// - BCD adjust adds 6 to low nibble if above 9 or half carry set.
// - Decrement subtracts one, destination bit picks target, five flags updated.
// - Increment adds one, five flags updated; FFh gives zero with carry.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Dec-skip-zero stores result, skips next word on zero, flags kept.
// - Dec-skip-nonzero stores result, skips next word on nonzero, flags kept.
// - Skipping a two-word instruction takes three cycles, both words no-op.
// - Absolute jump loads 20-bit literal into program counter bits 20..1.
// - Jump first word EFh holds low literal; second word Fh holds high.
// - Jump takes two cycles; PC written at first cycle end, then no-op.
// - Bank bit 0 resolves the address in the access bank.
// - Bank bit 1 uses the bank pointer to pick the data bank.
// - Extended set, bank bit 0, address up to 5Fh: indexed offset.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module cpu_incdec_bcd_jump_ops (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [15:0] instr_i,
    output logic      [20:0] fetch_addr_o,
    output logic      [11:0] mem_addr_o,
    output logic             mem_rd_o,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             mem_wr_o,
    output logic      [7:0]  mem_wdata_o,
    output logic      [3:0]  phase_o
);
    regs_if rif ();

    core_pkg::phase_t phase_reg;
    core_pkg::phase_t phase_next;
    core_pkg::cycle_t cyc_reg;
    core_pkg::cycle_t cyc_next;
    logic [15:0] ir_reg;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic [11:0] addr_reg;
    logic [11:0] addr_next;
    logic [7:0]  opnd_reg;
    logic [7:0]  result_reg;
    logic [7:0]  result_next;
    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    logic [4:0]  flags_reg;
    logic [4:0]  flags_next;
    logic [4:0]  fcalc_reg;
    logic [4:0]  fcalc_next;
    logic        skip_more_reg;
    logic        skip_more_next;
    logic        skip_tail_reg;
    logic        skip_tail_next;

    // Register slave answers with no wait states
    reg_slave u_regs (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .hsel_i   (hsel_i),
        .haddr_i  (haddr_i),
        .htrans_i (htrans_i),
        .hwrite_i (hwrite_i),
        .hready_i (hready_i),
        .hwdata_i (hwdata_i),
        .hrdata_o (hrdata_o),
        .rif      (rif.regs)
    );
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign rif.acc     = acc_reg;
    assign rif.flags   = flags_reg;
    assign rif.pc      = pc_reg;

    // Phase strobes; clearing the run bit freezes the core between edges
    wire ph_en = rif.run_en;
    wire q1    = ph_en && (phase_reg == core_pkg::PH_Q1);
    wire q2    = ph_en && (phase_reg == core_pkg::PH_Q2);
    wire q3    = ph_en && (phase_reg == core_pkg::PH_Q3);
    wire q4    = ph_en && (phase_reg == core_pkg::PH_Q4);
    wire exec  = (cyc_reg == core_pkg::CYC_EXEC);
    wire skip  = (cyc_reg == core_pkg::CYC_SKIP);
    wire jnop  = (cyc_reg == core_pkg::CYC_JNOP);

    // Four phases in a ring
    assign phase_next = !ph_en ? phase_reg :
                        (phase_reg == core_pkg::PH_Q1) ? core_pkg::PH_Q2 :
                        (phase_reg == core_pkg::PH_Q2) ? core_pkg::PH_Q3 :
                        (phase_reg == core_pkg::PH_Q3) ? core_pkg::PH_Q4 : core_pkg::PH_Q1;

    // Decode of the held instruction word
    wire [5:0] opc     = ir_reg[core_pkg::OPC_MSB:core_pkg::OPC_LSB];
    wire       is_dec  = (opc == core_pkg::OPC_MINUS);
    wire       is_inc  = (opc == core_pkg::OPC_PLUS);
    wire       is_dsz  = (opc == core_pkg::OPC_MINUS_SZ);
    wire       is_dsnz = (opc == core_pkg::OPC_MINUS_SNZ);
    wire       is_bcd  = (ir_reg == core_pkg::OP_BCD);
    wire       is_jump = (ir_reg[15:8] == core_pkg::OP_JUMP1);
    wire       is_byte = is_dec || is_inc || is_dsz || is_dsnz;
    wire       dest_f  = ir_reg[core_pkg::DEST_BIT];

    // File address resolution from the word being decoded
    wire [7:0] f_new   = instr_i[7:0];
    wire       a_new   = instr_i[core_pkg::BANK_BIT];
    wire       low_f   = (f_new <= core_pkg::INDEXED_MAX);
    wire       indexed = rif.ext_en && !a_new && low_f;
    wire [11:0] idx_addr = rif.index_base + {4'h0, f_new};
    wire [3:0] acc_bank = low_f ? core_pkg::ACC_LO_BANK : core_pkg::ACC_HI_BANK;
    assign addr_next = a_new   ? {rif.bank_pointer, f_new} :
                       indexed ? idx_addr :
                       {acc_bank, f_new};

    // Source operand: accumulator for BCD adjust, file data otherwise
    wire [7:0] src     = is_bcd ? acc_reg : mem_rdata_i;
    wire [7:0] dec_res = src - core_pkg::ONE8;
    wire [7:0] inc_res = src + core_pkg::ONE8;

    // BCD adjust; low fix may carry into the high nibble
    wire       lo_fix  = (src[3:0] > core_pkg::BCD_LIMIT) || flags_reg[core_pkg::FL_DC];
    wire [8:0] t1      = {1'b0, src} + (lo_fix ? core_pkg::BCD_LO6 : 9'h000);
    wire       hi_fix  = t1[8] || (t1[7:4] > core_pkg::BCD_LIMIT) || flags_reg[core_pkg::FL_C];
    wire [7:0] bcd_res = t1[7:0] + (hi_fix ? core_pkg::BCD_HI6 : 8'h00);

    assign result_next = is_bcd ? bcd_res : is_inc ? inc_res : dec_res;

    // Flags: decrement carry means no borrow
    wire [7:0] ar  = is_inc ? inc_res : dec_res;
    wire       a_c = is_inc ? (src == core_pkg::BYTE_MAX) : (src != 8'h00);
    wire       a_d = is_inc ? (src[3:0] == core_pkg::NIB_MAX) : (src[3:0] != 4'h0);
    wire       a_v = is_inc ? (src == core_pkg::SIGN_MAX) : (src == core_pkg::SIGN_MIN);
    wire [4:0] ar_flags = {ar[7], a_v, (ar == 8'h00), a_d, a_c};
    wire [4:0] bcd_flags = flags_reg | {4'h0, hi_fix};
    assign fcalc_next = is_bcd ? bcd_flags : ar_flags;

    // Commit in Q4; skip forms keep the flags
    wire commit  = exec && q4;
    wire to_acc  = commit && ((is_byte && !dest_f) || is_bcd);
    wire upd_fl  = commit && (is_dec || is_inc || is_bcd);
    assign acc_next   = to_acc ? result_reg : acc_reg;
    assign flags_next = upd_fl ? fcalc_reg : flags_reg;

    // Data memory strobes
    assign mem_addr_o  = addr_reg;
    assign mem_rd_o    = exec && q2 && is_byte;
    assign mem_wr_o    = commit && is_byte && dest_f;
    assign mem_wdata_o = result_reg;

    // Skip and jump decisions at the end of the cycle
    wire res_zero  = (result_reg == 8'h00);
    wire skip_take = commit && ((is_dsz && res_zero) || (is_dsnz && !res_zero));
    wire word2_ok  = (instr_i[15:12] == core_pkg::OP_WORD2);
    wire jump_take = commit && is_jump && word2_ok;
    wire [20:0] jump_pc = {instr_i[11:0], ir_reg[7:0], 1'b0};

    // A skipped word that opens a two-word instruction costs one more cycle
    assign skip_more_next = (skip && q1 && !skip_tail_reg) ? core_pkg::two_word(instr_i) :
                            (skip && q4) ? 1'b0 : skip_more_reg;
    assign skip_tail_next = (skip && q4) ? skip_more_reg : skip_tail_reg;

    assign cyc_next = !q4 ? cyc_reg :
                      jump_take ? core_pkg::CYC_JNOP :
                      skip_take ? core_pkg::CYC_SKIP :
                      (skip && skip_more_reg) ? core_pkg::CYC_SKIP : core_pkg::CYC_EXEC;

    // Fetch advances each Q1 except in the jump bubble
    assign pc_next = jump_take ? jump_pc :
                     (q1 && !jnop) ? pc_reg + core_pkg::PC_STEP : pc_reg;

    // Sequencing state
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_reg     <= core_pkg::PH_Q1;
            cyc_reg       <= core_pkg::CYC_EXEC;
            pc_reg        <= 21'h000000;
            skip_more_reg <= 1'b0;
            skip_tail_reg <= 1'b0;
        end
        else
        begin
            phase_reg     <= phase_next;
            cyc_reg       <= cyc_next;
            pc_reg        <= pc_next;
            skip_more_reg <= skip_more_next;
            skip_tail_reg <= skip_tail_next;
        end
    end

    // Decode capture in Q1
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ir_reg   <= 16'h0000;
            addr_reg <= 12'h000;
        end
        else if (exec && q1)
        begin
            ir_reg   <= instr_i;
            addr_reg <= addr_next;
        end
    end

    // Process in Q3, results held for the Q4 commit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opnd_reg   <= 8'h00;
            result_reg <= 8'h00;
            fcalc_reg  <= 5'h00;
        end
        else if (exec && q3)
        begin
            opnd_reg   <= src;
            result_reg <= result_next;
            fcalc_reg  <= fcalc_next;
        end
    end

    // Architectural accumulator and flags
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_reg   <= 8'h00;
            flags_reg <= 5'h00;
        end
        else
        begin
            acc_reg   <= acc_next;
            flags_reg <= flags_next;
        end
    end

    assign fetch_addr_o = pc_reg;
    assign phase_o      = phase_reg;

    // Checks on the running core
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !rif.run_en);

    // Commit cycle marker shared by the result checks
    wire dq4 = commit;

    bcd_low_keep_a: assert property (
        dq4 && is_bcd && (opnd_reg[3:0] <= core_pkg::BCD_LIMIT) && !flags_reg[core_pkg::FL_DC]
        |=> acc_reg[3:0] == $past(opnd_reg[3:0]))
        else $error("low nibble changed without cause");

    // Helper: high fix as latched at Q3
    logic hi_fix_q;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hi_fix_q <= 1'b0;
        else if (exec && q3)
            hi_fix_q <= hi_fix;
    end

    bcd_low_add_a: assert property (
        dq4 && is_bcd && (opnd_reg[3:0] > core_pkg::BCD_LIMIT)
        |=> acc_reg[3:0] == 4'($past(opnd_reg[3:0]) + 4'h6))
        else $error("low nibble not adjusted by six");

    bcd_carry_a: assert property (
        dq4 && is_bcd && hi_fix_q |=> flags_reg[core_pkg::FL_C]
        && flags_reg[4:1] == $past(flags_reg[4:1]))
        else $error("adjust carry or other flags wrong");

    minus_dest_a: assert property (
        dq4 && is_dec && !dest_f |=> acc_reg == 8'($past(opnd_reg) - 8'h01))
        else $error("decrement result not in accumulator");

    plus_wrap_a: assert property (
        dq4 && is_inc && opnd_reg == core_pkg::BYTE_MAX
        |=> flags_reg[core_pkg::FL_C] && flags_reg[core_pkg::FL_Z] && (dest_f || acc_reg == 8'h00))
        else $error("increment of FFh flags wrong");

    file_write_a: assert property (
        mem_wr_o |-> is_byte && dest_f && acc_next == acc_reg && mem_wdata_o == result_reg)
        else $error("file write with wrong destination");

    // Skip forms: stored result, skip length, flags left alone
    skip_store_a: assert property (
        dq4 && (is_dsz || is_dsnz) && dest_f |-> mem_wr_o && mem_wdata_o == 8'(opnd_reg - 8'h01))
        else $error("skip form did not store its result");

    skip_zero_a: assert property (
        dq4 && is_dsz && res_zero |=> skip && $stable(flags_reg) ##3 skip)
        else $error("zero skip did not happen");

    skip_nonzero_a: assert property (
        dq4 && is_dsnz && !res_zero |=> skip ##3 skip && $stable(flags_reg))
        else $error("nonzero skip did not happen");

    skip_two_a: assert property (
        skip && q1 && !skip_tail_reg && core_pkg::two_word(instr_i) |-> ##4 skip ##3 skip ##1 exec)
        else $error("two-word skip length wrong");

    // Jump target and the bubble that follows it
    jump_load_a: assert property (
        jump_take |=> pc_reg == {$past(instr_i[11:0]), $past(ir_reg[7:0]), 1'b0})
        else $error("jump target wrong");

    jump_bubble_a: assert property (
        jump_take |=> jnop ##3 jnop ##1 exec && $stable(pc_reg))
        else $error("jump bubble wrong");

    // Without the extended set the access bank splits at the indexed limit
    wire acc_lo_hit = (mem_addr_o[7:0] <= core_pkg::INDEXED_MAX);
    access_bank_a: assert property (
        mem_rd_o && !ir_reg[core_pkg::BANK_BIT] && !rif.ext_en
        |-> mem_addr_o[11:8] == (acc_lo_hit ? core_pkg::ACC_LO_BANK : core_pkg::ACC_HI_BANK))
        else $error("access bank half wrong");

    bank_ptr_a: assert property (
        mem_rd_o && ir_reg[core_pkg::BANK_BIT] |-> mem_addr_o[11:8] == rif.bank_pointer)
        else $error("bank pointer not used");

    indexed_a: assert property (
        exec && q1 && rif.ext_en && !instr_i[8] && instr_i[7:0] <= core_pkg::INDEXED_MAX
        |=> addr_reg == $past(rif.index_base) + {4'h0, $past(instr_i[7:0])})
        else $error("indexed offset address wrong");

    phase_ring_a: assert property (
        q1 |=> phase_reg == core_pkg::PH_Q2 ##1 phase_reg == core_pkg::PH_Q3 ##1 q4)
        else $error("phase order broken");

    // Main scenarios: adjust with carry, long skip, far jump, indexed window
    cov_bcd:  cover property (dq4 && is_bcd && hi_fix_q);
    cov_nz:   cover property (dq4 && is_dsnz && !res_zero);
    cov_skip: cover property (skip && q1 && core_pkg::two_word(instr_i));
    cov_jump: cover property (jump_take);
    cov_idx:  cover property (exec && q1 && indexed);
endmodule

// [test/prog_data_model.sv]
// Program store and data memory model facing the execution slice
`timescale 1ns/1ps
module prog_data_model (
    input  wire logic        clk_i,
    input  wire logic [20:0] fetch_addr_i,
    output logic      [15:0] instr_o,
    input  wire logic [11:0] mem_addr_i,
    input  wire logic        mem_rd_i,
    input  wire logic        mem_wr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic      [7:0]  mem_rdata_o
);
    logic [15:0] rom [256];
    logic [7:0]  ram [4096];
    logic [7:0]  rdata_reg = 8'h5A;

    // Fetch is combinational; the small store aliases high program addresses
    assign instr_o     = rom[fetch_addr_i[8:1]];
    assign mem_rdata_o = rdata_reg;

    // Read data stands one clock after the strobe, then churns so stale data is never seen
    always @(posedge clk_i)
    begin
        if (mem_rd_i)
            rdata_reg <= ram[mem_addr_i];
        else
            rdata_reg <= ~rdata_reg;
        if (mem_wr_i)
            ram[mem_addr_i] <= mem_wdata_i;
    end
endmodule

// [test/cpu_incdec_bcd_jump_ops_bench.sv]
// Self-checking bench: programs run from the model, results read over the register bus and from the model memory
`timescale 1ns/1ps
module cpu_incdec_bcd_jump_ops_bench;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [15:0] instr;
    logic [20:0] fetch_addr;
    logic [11:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [3:0]  phase;
    logic [31:0] rd;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          pc_w;
    int          i;
    logic [7:0]  bin [3] = '{8'hA4, 8'hCD, 8'h0F};
    logic [12:0] bout [3] = '{13'h1105, 13'h1134, 13'h0216};

    cpu_incdec_bcd_jump_ops uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .instr_i(instr),
        .fetch_addr_o(fetch_addr), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_rdata_i(mem_rdata),
        .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .phase_o(phase));

    prog_data_model mdl (.clk_i(clk_i), .fetch_addr_i(fetch_addr), .instr_o(instr), .mem_addr_i(mem_addr),
        .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));

    // 250 MHz core clock
    always #2 clk_i = ~clk_i;

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_ram(input string what, input logic [11:0] a, input logic [7:0] e);
        check(what, {24'h0, mdl.ram[a]}, {24'h0, e});
    endtask

    // Single bus transfer; waits on ready in both phases, read data taken at the last edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [15:0] bop(input logic [5:0] opc, input logic d, input logic a,
                                        input logic [7:0] f);
        return {opc, d, a, f};
    endfunction

    // Fresh store of single-cycle no-ops; four lead cycles give room to configure
    task automatic begin_prog();
        for (int n = 0; n < 4096; n++)
            mdl.ram[n] = 8'h00;
        for (int n = 0; n < 256; n++)
            mdl.rom[n] = 16'h0000;
        pc_w = 4;
    endtask

    task automatic put(input logic [15:0] w);
        mdl.rom[pc_w] = w;
        pc_w++;
    endtask

    // Park a self jump at k, reset, configure, wait for the halt, then read the accumulator word
    task automatic go(input logic [19:0] k, input logic [7:0] ctrl);
        mdl.rom[k[7:0]] = {core_pkg::OP_JUMP1, k[7:0]};
        mdl.rom[k[7:0] + 8'h01] = {core_pkg::OP_WORD2, k[19:8]};
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("phase in reset", {28'h0, phase}, {28'h0, core_pkg::PH_Q1});
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        ahb(1'b0, core_pkg::OFS_CTRL, 32'h0);
        check("ctrl reset", rd, core_pkg::CTRL_RESET);
        ahb(1'b1, core_pkg::OFS_CTRL, {24'h0, ctrl});
        ahb(1'b1, core_pkg::OFS_INDEX, 32'h200);
        rd = 32'h0;
        for (int n = 0; n < 300 && rd !== {11'h0, k, 1'b0}; n++)
            ahb(1'b0, core_pkg::OFS_PC, 32'h0);
        check("halt pc", rd, {11'h0, k, 1'b0});
        // Two instruction cycles of four clocks let the last operation commit
        repeat (8) @(posedge clk_i);
        ahb(1'b0, core_pkg::OFS_ACC, 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // One edge apart, so the per-test reset never lands in the same step
        @(posedge clk_i);
        // Adjust after increment: high fix, both fixes, low fix from nibble carry only
        for (i = 0; i < 3; i++)
        begin
            begin_prog();
            mdl.ram[12'h010] = bin[i];
            put(bop(core_pkg::OPC_PLUS, 1'b0, 1'b0, 8'h10));
            put(core_pkg::OP_BCD);
            go(pc_w[19:0], 8'h01);
            check("bcd acc", rd, {19'h0, bout[i]});
        end
        $display("end of test bcd_adjust");
        // Increment wraps into the file, decrement lands in the accumulator
        begin_prog();
        mdl.ram[12'h011] = 8'hFF;
        mdl.ram[12'h012] = 8'h80;
        put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b0, 8'h11));
        put(bop(core_pkg::OPC_MINUS, 1'b0, 1'b0, 8'h12));
        go(pc_w[19:0], 8'h01);
        check("dec acc", rd, 32'h0000097F);
        chk_ram("inc file", 12'h011, 8'h00);
        chk_ram("dec file kept", 12'h012, 8'h80);
        $display("end of test inc_dec");
        // Both skip kinds, one over a two-word jump; flags must survive
        begin_prog();
        mdl.ram[12'h020] = 8'h01;
        mdl.ram[12'h021] = 8'h05;
        mdl.ram[12'h022] = 8'h03;
        mdl.ram[12'h023] = 8'h10;
        mdl.ram[12'h024] = 8'h09;
        put(bop(core_pkg::OPC_PLUS, 1'b0, 1'b0, 8'h23));
        put(bop(core_pkg::OPC_MINUS_SZ, 1'b1, 1'b0, 8'h20));
        put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b0, 8'h21));
        put(bop(core_pkg::OPC_MINUS_SNZ, 1'b1, 1'b0, 8'h22));
        put(16'hEF00);
        put(16'hF000);
        put(bop(core_pkg::OPC_MINUS_SZ, 1'b0, 1'b0, 8'h24));
        go(pc_w[19:0], 8'h01);
        check("skip acc", rd, 32'h00000008);
        chk_ram("skip zero file", 12'h020, 8'h00);
        chk_ram("skipped op", 12'h021, 8'h05);
        chk_ram("skip nonzero file", 12'h022, 8'h02);
        $display("end of test skips");
        // Bank pointer, access bank halves, indexed window with the extended set
        for (i = 0; i < 2; i++)
        begin
            begin_prog();
            put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b1, 8'h30));
            put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b0, 8'h70));
            put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b0, 8'h40));
            go(pc_w[19:0], {4'h3, 2'h0, i[0], 1'b1});
            chk_ram("bank file", 12'h330, 8'h01);
            chk_ram("access high", 12'hF70, 8'h01);
            chk_ram("access low", i[0] ? 12'h240 : 12'h040, 8'h01);
        end
        $display("end of test banks");
        // Far jump with a nonzero upper literal; the word after it never runs
        begin_prog();
        put({core_pkg::OP_JUMP1, 8'h40});
        put({core_pkg::OP_WORD2, 12'h123});
        put(bop(core_pkg::OPC_PLUS, 1'b1, 1'b0, 8'h50));
        go(20'h12340, 8'h01);
        chk_ram("jump shadow", 12'h050, 8'h00);
        ahb(1'b0, 8'h10, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("end of test jump");
        close_out();
    end
endmodule
